// ==== lwk_chk.sv ====
// port assertions for the wake-up register bank
`timescale 1ns/1ps
module lwk_chk #(
	parameter int unsigned SEC_CYC = 10000000
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire lwk_pkg::lwk_req_t i_req,
	input wire lwk_pkg::lwk_fe_t i_fe,
	input wire logic [7:0] o_rdata,
	input wire logic o_wake,
	input wire logic o_receiving,
	input wire lwk_pkg::lwk_ctl_t o_ctl
);
	import lwk_pkg::*;
	logic rd_ok;
	// a read only counts with the clock enable high
	assign rd_ok = i_req.rd && i_ce;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);
	a_chpwr_unused:
	assert property (rd_ok && i_req.addr == 6'h00 |=> o_rdata[7:6] == 2'h0)
		else $error("unused power bits read nonzero");
	a_rxopt_gap:
	assert property (rd_ok && i_req.addr == 6'h01 |=> o_rdata[3] == 1'b0)
		else $error("unassigned option bit read nonzero");
	a_tol_reserved:
	assert property (rd_ok && i_req.addr == 6'h02 |=> o_rdata[4:2] == 3'h0)
		else $error("reserved tolerance bits read nonzero");
	a_awu_unused:
	assert property (rd_ok && i_req.addr == 6'h08 |=> o_rdata[7:3] == 5'h00)
		else $error("unused interval bits read nonzero");
	a_rsv_nine:
	assert property (rd_ok && i_req.addr == 6'h09 |=> o_rdata == 8'h00)
		else $error("reserved register read nonzero");
	a_ss_width:
	assert property (rd_ok && i_req.addr inside {[6'h0a:6'h0c]}
		|=> o_rdata[7:5] == 3'h0)
		else $error("strength upper bits read nonzero");
	a_wake_recv:
	assert property (o_receiving |-> o_wake)
		else $error("receiving without wake high");
	a_clear_wake:
	assert property (i_req.cmd && i_ce && i_req.addr == 6'h00
		&& !i_fe.corr_hit && !i_fe.freq_hit |-> ##[1:2] !o_receiving)
		else $error("clear wake did not leave receive");
endmodule : lwk_chk
bind lwk_regbank lwk_chk #(.SEC_CYC(SEC_CYC)) i_lwk_chk (.i_clk_sys(i_clk_sys),
	.i_rstn(i_rstn), .i_ce(i_ce), .i_req(i_req), .i_fe(i_fe),
	.o_rdata(o_rdata), .o_wake(o_wake), .o_receiving(o_receiving),
	.o_ctl(o_ctl));

// ==== lwk_host.sv ====
// host model issuing register requests to the bank
`timescale 1ns/1ps
module lwk_host (
	input wire logic i_clk_sys,
	input wire logic [7:0] i_rdata,
	output lwk_pkg::lwk_req_t o_req
);
	import lwk_pkg::*;
	initial o_req = '0;
	// one pulse per request; idle qualifiers zero, address and data inverted so no stale value
	task automatic put(input logic [2:0] k, input logic [5:0] a,
		input logic [7:0] v);
		@(posedge i_clk_sys);
		o_req <= {k, a, v};
		@(posedge i_clk_sys);
		o_req <= {3'b000, ~a, ~v};
	endtask : put
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		put(3'b100, a, v);
	endtask : wr
	// read data lands at the taking edge, sampled once settled
	task automatic rd(input logic [5:0] a, output logic [7:0] v);
		put(3'b010, a, 8'h00);
		#1;
		v = i_rdata;
	endtask : rd
	task automatic cmd(input logic [5:0] a);
		put(3'b001, a, 8'h00);
	endtask : cmd
endmodule : lwk_host

// ==== lwk_params.svh ====
// register offsets, write masks, command codes, reset values and timing counts
`ifndef LWK_PARAMS_SVH
`define LWK_PARAMS_SVH
`define LWK_ADDR_CHPWR 6'h00
`define LWK_ADDR_RXOPT 6'h01
`define LWK_ADDR_TOL 6'h02
`define LWK_ADDR_SLENV 6'h03
`define LWK_ADDR_GDOFF 6'h04
`define LWK_ADDR_PAT2 6'h05
`define LWK_ADDR_PAT1 6'h06
`define LWK_ADDR_TOBR 6'h07
`define LWK_ADDR_AWU 6'h08
`define LWK_ADDR_RSV9 6'h09
`define LWK_ADDR_SS1 6'h0a
`define LWK_ADDR_SS2 6'h0b
`define LWK_ADDR_SS3 6'h0c
`define LWK_ADDR_FWK 6'h0d
`define LWK_RST_CHPWR 8'h0e
`define LWK_RST_RXOPT 8'h23
`define LWK_RST_TOL 8'h00
`define LWK_RST_SLENV 8'h20
`define LWK_RST_GDOFF 8'h10
`define LWK_RST_PAT2 8'h69
`define LWK_RST_PAT1 8'h96
`define LWK_RST_TOBR 8'h0b
`define LWK_RST_AWU 8'h00
`define LWK_MASK_CHPWR 8'h3f
`define LWK_MASK_RXOPT 8'hf7
`define LWK_MASK_TOL 8'he3
`define LWK_MASK_AWU 8'h07
`define LWK_MASK_SS 8'h1f
`define LWK_CMD_CLEAR_WAKE 6'h00
`define LWK_CMD_CLEAR_FALSE 6'h03
`define LWK_CMD_PRESET 6'h04
`define LWK_SLOT_NS 1000000
`define LWK_CLK_NS 100
`define LWK_SLOT_CYC (`LWK_SLOT_NS / `LWK_CLK_NS)
`define LWK_WAKE_PULSE_NS 128000
`define LWK_WAKE_PULSE_CYC (`LWK_WAKE_PULSE_NS / `LWK_CLK_NS)
`define LWK_TO_UNIT_MS 50
`endif

// ==== lwk_pkg.sv ====
// types shared by the wake-up register bank
package lwk_pkg;
	typedef enum logic [1:0] {
		LWK_MD_LISTEN,
		LWK_MD_RECEIVE
	} lwk_mode_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic cmd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} lwk_req_t;
	typedef struct packed {
		logic carrier;
		logic corr_hit;
		logic freq_hit;
		logic false_wake;
		logic [14:0] strength;
	} lwk_fe_t;
	typedef struct packed {
		logic [2:0] ch_on;
		logic gain_first_burst_only;
		logic gain_bidirectional;
		logic double_pattern_enable;
		logic slicer_hysteresis_edge;
		logic [15:0] pattern;
	} lwk_ctl_t;
endpackage : lwk_pkg

// ==== lwk_regbank.sv ====
// configuration/status register bank and wake sequencing
`timescale 1ns/1ps
`include "lwk_params.svh"
// Operation
// - duty-cycle bit powers active channels on and off with chosen off time
// - off-time field selects 1, 2, 4 or 8 ms off period
// - first-burst bit limits gain control to first carrier burst
// - gain direction bit resets to one, enabling up and down gain
// - double-pattern bit requires two correlations before wake-up
// - wake pattern in two bytes, resets 0x69 and 0x96
// - edge-select bit picks hysteresis on both or positive edges only
// - slicer time constant resets 100, envelope time constant resets 000
// - wake-up frequency tolerance field, bits 1:0, resets 00
// - pattern tolerance bits 6:5 reset 00; bits 4:2 reserved zero
// - artificial wake-up field decodes disabled, 1s up to 2 hours
// - five-bit bit-rate field resets to 01011
// - three-bit receive timeout field resets to 000
// - slicer threshold-reduce bit at register 2 bit 7
// - slicer absolute-reference bit at register 1 bit 7
// - gain reduction field resets 0000, damping field resets 01
// - elapsed artificial interval without activity pulses wake for 128 us
// - correlation counts for wake only when enabled, else frequency alone
// - scan mode powers one channel per 1 ms slot, order one three two
// - receive returns to listening on clear-wake or timeout expiry
module lwk_regbank #(
	parameter int unsigned SEC_CYC = 10000000
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire lwk_pkg::lwk_req_t i_req,
	input wire lwk_pkg::lwk_fe_t i_fe,
	output logic [7:0] o_rdata,
	output logic o_wake,
	output logic o_receiving,
	output lwk_pkg::lwk_ctl_t o_ctl
);
	import lwk_pkg::*;

	localparam int unsigned SLOT_CYC = `LWK_SLOT_CYC;
	localparam int unsigned PULSE_CYC = `LWK_WAKE_PULSE_CYC;
	localparam int unsigned TO_UNIT = `LWK_TO_UNIT_MS;

	typedef struct packed {
		logic [7:0] chpwr;
		logic [7:0] rxopt;
		logic [7:0] tol;
		logic [7:0] slenv;
		logic [7:0] gdoff;
		logic [7:0] pat2;
		logic [7:0] pat1;
		logic [7:0] tobr;
		logic [7:0] awu;
		logic [7:0] fwk;
		logic [7:0] rdata;
		lwk_mode_t mode;
		logic pat_seen;
		logic [13:0] slot_cnt;
		logic [1:0] scan_idx;
		logic [3:0] off_ms;
		logic off_phase;
		// forty bits: two hours of a 10 MHz clock will not fit in 32
		logic [39:0] awu_cnt;
		logic [13:0] pulse_cnt;
		logic [31:0] rx_ms;
		logic wake;
		// registered copies that drive the wake and mode pins
		logic wake_q;
		logic recv_q;
		lwk_ctl_t ctl;
	} lwk_state_t;

	lwk_state_t st_reg;
	lwk_state_t st_next;
	logic rst_s1_reg;
	logic rst_s2_reg;
	logic [31:0] awu_limit;
	// last count of the artificial interval, in clock cycles
	logic [39:0] awu_end;
	logic [31:0] to_limit;
	logic [3:0] off_len;
	logic [2:0] scan_ch;
	logic [2:0] en;
	logic wake_hit;

	////////////////////////////////////////////////////////////////////
	// reset release through two flops
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// decodes of timing fields
	always_comb begin
		case (st_reg.gdoff[7:6])
			2'b00: off_len = 4'h1;
			2'b01: off_len = 4'h2;
			2'b10: off_len = 4'h4;
			default: off_len = 4'h8;
		endcase
		case (st_reg.awu[2:0])
			3'h1: awu_limit = 32'h1;
			3'h2: awu_limit = 32'h5;
			3'h3: awu_limit = 32'h14;
			3'h4: awu_limit = 32'h78;
			3'h5: awu_limit = 32'h384;
			3'h6: awu_limit = 32'he10;
			3'h7: awu_limit = 32'h1c20;
			default: awu_limit = 32'h0;
		endcase
		// product taken at forty bits; the 15 min, 1 h and 2 h settings
		// would wrap a 32-bit product and fire far too early.
		// the value for a disabled field wraps too, but the counter is
		// held at zero in that case so it is never compared.
		awu_end = 40'(awu_limit) * 40'(SEC_CYC) - 40'h1;
		// timeout step size is a guess; zero disables it
		to_limit = 32'(st_reg.tobr[7:5]) * 32'(TO_UNIT);
		case (st_reg.scan_idx)
			2'd0: scan_ch = 3'b001;
			2'd1: scan_ch = 3'b100;
			default: scan_ch = 3'b010;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		st_next = st_reg;
		en = {st_reg.chpwr[2], st_reg.chpwr[3], st_reg.chpwr[1]};
		wake_hit = st_reg.rxopt[1] ? i_fe.corr_hit : i_fe.freq_hit;
		// register write; read-only and reserved ignored
		if (i_req.wr) begin
			case (i_req.addr)
				`LWK_ADDR_CHPWR: st_next.chpwr = i_req.wdata & `LWK_MASK_CHPWR;
				`LWK_ADDR_RXOPT: st_next.rxopt = i_req.wdata & `LWK_MASK_RXOPT;
				`LWK_ADDR_TOL: st_next.tol = i_req.wdata & `LWK_MASK_TOL;
				`LWK_ADDR_SLENV: st_next.slenv = i_req.wdata;
				`LWK_ADDR_GDOFF: st_next.gdoff = i_req.wdata;
				`LWK_ADDR_PAT2: st_next.pat2 = i_req.wdata;
				`LWK_ADDR_PAT1: st_next.pat1 = i_req.wdata;
				`LWK_ADDR_TOBR: st_next.tobr = i_req.wdata;
				`LWK_ADDR_AWU: st_next.awu = i_req.wdata & `LWK_MASK_AWU;
				default: st_next.rdata = st_reg.rdata;
			endcase
		end
		// register read, captured a cycle later
		if (i_req.rd) begin
			case (i_req.addr)
				`LWK_ADDR_CHPWR: st_next.rdata = st_reg.chpwr;
				`LWK_ADDR_RXOPT: st_next.rdata = st_reg.rxopt;
				`LWK_ADDR_TOL: st_next.rdata = st_reg.tol;
				`LWK_ADDR_SLENV: st_next.rdata = st_reg.slenv;
				`LWK_ADDR_GDOFF: st_next.rdata = st_reg.gdoff;
				`LWK_ADDR_PAT2: st_next.rdata = st_reg.pat2;
				`LWK_ADDR_PAT1: st_next.rdata = st_reg.pat1;
				`LWK_ADDR_TOBR: st_next.rdata = st_reg.tobr;
				`LWK_ADDR_AWU: st_next.rdata = st_reg.awu;
				`LWK_ADDR_SS1: st_next.rdata = {3'h0, i_fe.strength[4:0]};
				`LWK_ADDR_SS2: st_next.rdata = {3'h0, i_fe.strength[9:5]};
				`LWK_ADDR_SS3: st_next.rdata = {3'h0, i_fe.strength[14:10]};
				`LWK_ADDR_FWK: st_next.rdata = st_reg.fwk;
				default: st_next.rdata = 8'h00;
			endcase
		end
		// false wake counter saturates; clear beats count
		if (i_fe.false_wake && st_reg.fwk != 8'hff) begin
			st_next.fwk = st_reg.fwk + 8'h01;
		end
		// 1 ms slot timebase
		if (st_reg.slot_cnt == 14'(SLOT_CYC - 1)) begin
			st_next.slot_cnt = 14'h0;
		end else begin
			st_next.slot_cnt = st_reg.slot_cnt + 14'h1;
		end
		if (st_reg.slot_cnt == 14'(SLOT_CYC - 1)) begin
			// advance scan slot in fixed rotation; a disabled channel's slot powers none
			st_next.scan_idx = (st_reg.scan_idx == 2'd2) ? 2'd0 :
				st_reg.scan_idx + 2'd1;
			// on one slot, then off for chosen period
			if (!st_reg.off_phase) begin
				st_next.off_phase = st_reg.chpwr[5];
				st_next.off_ms = 4'h1;
			end else if (st_reg.off_ms >= off_len) begin
				st_next.off_phase = 1'b0;
			end else begin
				st_next.off_ms = st_reg.off_ms + 4'h1;
			end
			if (st_reg.mode == LWK_MD_RECEIVE) begin
				st_next.rx_ms = st_reg.rx_ms + 32'h1;
			end
		end
		// channel power outputs
		if (st_reg.chpwr[0]) begin
			st_next.ctl.ch_on = 3'b000;
		end else if (i_fe.carrier || st_reg.mode == LWK_MD_RECEIVE) begin
			st_next.ctl.ch_on = en;
		end else if (st_reg.chpwr[4]) begin
			st_next.ctl.ch_on = en & scan_ch;
		end else if (st_reg.chpwr[5] && st_reg.off_phase) begin
			st_next.ctl.ch_on = 3'b000;
		end else begin
			st_next.ctl.ch_on = en;
		end
		// wake decision in listening mode, timeout exit in receive mode
		case (st_reg.mode)
			LWK_MD_LISTEN: begin
				if (wake_hit && !st_reg.chpwr[0]) begin
					if (st_reg.rxopt[2] && st_reg.rxopt[1] &&
						!st_reg.pat_seen) begin
						st_next.pat_seen = 1'b1;
					end else begin
						st_next.pat_seen = 1'b0;
						st_next.mode = LWK_MD_RECEIVE;
						st_next.rx_ms = 32'h0;
						st_next.wake = 1'b1;
					end
				end
			end
			LWK_MD_RECEIVE: begin
				if (to_limit != 32'h0 && st_reg.rx_ms >= to_limit) begin
					st_next.mode = LWK_MD_LISTEN;
					st_next.wake = 1'b0;
				end
			end
			default: st_next.mode = LWK_MD_LISTEN;
		endcase
		// artificial wake counter, reset by any activity
		// carrier is the only activity seen here; a host write does not
		// restart the window, so the pulse period stays predictable
		if (i_fe.carrier || st_reg.awu[2:0] == 3'h0) begin
			st_next.awu_cnt = 40'h0;
		end else if (st_reg.awu_cnt >= awu_end) begin
			st_next.awu_cnt = 40'h0;
			st_next.pulse_cnt = 14'(PULSE_CYC);
		end else begin
			st_next.awu_cnt = st_reg.awu_cnt + 40'h1;
		end
		// pulse down-counter; mid-pulse the decrement wins over a new interval's reload
		if (st_reg.pulse_cnt != 14'h0) begin
			st_next.pulse_cnt = st_reg.pulse_cnt - 14'h1;
		end
		// direct commands
		if (i_req.cmd) begin
			case (i_req.addr)
				`LWK_CMD_CLEAR_WAKE: begin
					st_next.mode = LWK_MD_LISTEN;
					st_next.wake = 1'b0;
				end
				`LWK_CMD_CLEAR_FALSE: st_next.fwk = 8'h00;
				`LWK_CMD_PRESET: begin
					st_next.chpwr = `LWK_RST_CHPWR;
					st_next.rxopt = `LWK_RST_RXOPT;
					st_next.tol = `LWK_RST_TOL;
					st_next.slenv = `LWK_RST_SLENV;
					st_next.gdoff = `LWK_RST_GDOFF;
					st_next.pat2 = `LWK_RST_PAT2;
					st_next.pat1 = `LWK_RST_PAT1;
					st_next.tobr = `LWK_RST_TOBR;
					st_next.awu = `LWK_RST_AWU;
				end
				default: st_next.pat_seen = st_reg.pat_seen;
			endcase
		end
		st_next.ctl.gain_first_burst_only = st_reg.rxopt[6];
		st_next.ctl.gain_bidirectional = st_reg.rxopt[5];
		st_next.ctl.double_pattern_enable = st_reg.rxopt[2];
		st_next.ctl.slicer_hysteresis_edge = st_reg.slenv[6];
		st_next.ctl.pattern = {st_reg.pat1, st_reg.pat2};
		// pin copies taken from the next state, so the pins
		// show the same cycle as the mode and pulse flops would, but
		// leave the module straight from a flop with no gate behind.
		// these lines must stay last: every earlier update of mode,
		// wake and pulse_cnt in this process has to be seen here
		st_next.wake_q = st_next.wake | (st_next.pulse_cnt != 14'h0);
		st_next.recv_q = (st_next.mode == LWK_MD_RECEIVE);
	end

	////////////////////////////////////////////////////////////////////
	// state register; reset values
	always_ff @(posedge i_clk_sys or negedge rst_s2_reg) begin
		if (!rst_s2_reg) begin
			st_reg <= '0;
			st_reg.chpwr <= `LWK_RST_CHPWR;
			st_reg.rxopt <= `LWK_RST_RXOPT;
			st_reg.tol <= `LWK_RST_TOL;
			st_reg.slenv <= `LWK_RST_SLENV;
			st_reg.gdoff <= `LWK_RST_GDOFF;
			st_reg.pat2 <= `LWK_RST_PAT2;
			st_reg.pat1 <= `LWK_RST_PAT1;
			st_reg.tobr <= `LWK_RST_TOBR;
			st_reg.awu <= `LWK_RST_AWU;
			st_reg.mode <= LWK_MD_LISTEN;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs straight from flops; with the clock enable low every
	// output holds, since all of them live in the one state register.
	// read data holds until the next read, so a host may sample late
	assign o_rdata = st_reg.rdata;
	// wake pulse or receive wake level
	assign o_wake = st_reg.wake_q;
	assign o_receiving = st_reg.recv_q;
	// control bits lag their register by one cycle
	assign o_ctl = st_reg.ctl;
endmodule : lwk_regbank

// ==== lwk_regbank_test.sv ====
// self-checking bench for the wake-up register bank
`timescale 1ns/1ps
`include "lwk_params.svh"
module lwk_regbank_test;
	import lwk_pkg::*;
	// short second keeps the artificial wake run brief
	localparam int unsigned SEC = 2000;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic i_ce = 1'b1;
	lwk_req_t req;
	lwk_fe_t fe = '0;
	logic [7:0] rdata;
	logic wake;
	logic recv;
	lwk_ctl_t ctl;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [7:0] d;
	logic [7:0] rst_v [14] = '{8'h0e, 8'h23, 8'h00, 8'h20, 8'h10, 8'h69,
		8'h96, 8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] msk_v [14] = '{8'h3f, 8'hf7, 8'he3, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	always #50 i_clk_sys = ~i_clk_sys;
	lwk_host i_lwk_host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_req(req));
	lwk_regbank #(.SEC_CYC(SEC)) i_lwk_regbank (.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn), .i_ce(i_ce), .i_req(req), .i_fe(fe),
		.o_rdata(rdata), .o_wake(wake), .o_receiving(recv), .o_ctl(ctl));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [5:0] a, input logic [7:0] exp);
		i_lwk_host.rd(a, d);
		chk(d, exp);
	endtask : rc
	// one one-cycle correlation and/or frequency hit pulse, then settle
	task automatic hit(input logic [1:0] s);
		@(posedge i_clk_sys);
		fe.corr_hit <= s[0];
		fe.freq_hit <= s[1];
		@(posedge i_clk_sys);
		fe.corr_hit <= 1'b0;
		fe.freq_hit <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		#1;
	endtask : hit
	task automatic t_defaults;
		for (int a = 0; a < 14; a++) begin
			rc(a[5:0], rst_v[a]); // reset values
		end
	endtask : t_defaults
	// all ones everywhere, then readback through masks and preset
	task automatic t_write;
		for (int a = 0; a < 14; a++) begin
			i_lwk_host.wr(a[5:0], 8'hff);
		end
		for (int a = 0; a < 14; a++) begin
			rc(a[5:0], msk_v[a]); // masked readback
		end
		i_lwk_host.wr(6'h06, 8'ha5);
		i_lwk_host.wr(6'h05, 8'h3c);
		i_lwk_host.wr(6'h01, 8'h46);
		i_lwk_host.wr(6'h03, 8'h40);
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk(ctl.pattern[15:8], 8'ha5); // first byte high
		chk(ctl.pattern[7:0], 8'h3c); // second byte low
		chk({4'h0, ctl.gain_first_burst_only, ctl.gain_bidirectional,
			ctl.double_pattern_enable, ctl.slicer_hysteresis_edge},
			8'h0b); // control bits
		i_lwk_host.cmd(6'h04);
		t_defaults();
	endtask : t_write
	task automatic t_status;
		@(posedge i_clk_sys);
		fe.strength <= {5'h13, 5'h0a, 5'h15};
		rc(6'h0a, 8'h15); // channel one strength
		rc(6'h0b, 8'h0a); // channel two strength
		rc(6'h0c, 8'h13); // channel three strength
		repeat (3) begin
			@(posedge i_clk_sys);
			fe.false_wake <= 1'b1;
			@(posedge i_clk_sys);
			fe.false_wake <= 1'b0;
		end
		rc(6'h0d, 8'h03); // false wake count
		i_lwk_host.cmd(6'h03);
		rc(6'h0d, 8'h00); // count cleared
	endtask : t_status
	// successor in the one, three, two rotation
	function automatic logic [2:0] nxt(input logic [2:0] c);
		case (c)
			3'b001: return 3'b100;
			3'b100: return 3'b010;
			default: return 3'b001;
		endcase
	endfunction : nxt
	// channel power: scan, carrier, duty cycle, power down, enable, reset
	task automatic t_power;
		logic [2:0] c;
		chk({5'h0, ctl.ch_on}, 8'h07); // all on when listening
		i_lwk_host.wr(6'h00, 8'h1e);
		repeat (3) @(posedge i_clk_sys);
		#1;
		c = ctl.ch_on;
		chk({7'h0, c inside {3'b001, 3'b100, 3'b010}}, 8'h01);
		repeat (2) begin
			repeat (`LWK_SLOT_CYC) @(posedge i_clk_sys);
			#1;
			chk({5'h0, ctl.ch_on}, {5'h0, nxt(c)}); // order 1 3 2
			c = nxt(c);
		end
		@(posedge i_clk_sys);
		fe.carrier <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk({5'h0, ctl.ch_on}, 8'h07); // carrier turns all on
		@(posedge i_clk_sys);
		fe.carrier <= 1'b0;
		i_lwk_host.wr(6'h00, 8'h2e);
		repeat (3) @(posedge i_clk_sys);
		#1;
		c = ctl.ch_on;
		repeat (`LWK_SLOT_CYC) @(posedge i_clk_sys);
		#1;
		chk({5'h0, ctl.ch_on}, (c == 3'b111) ? 8'h00 : 8'h07);
		i_lwk_host.wr(6'h00, 8'h0f);
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk({5'h0, ctl.ch_on}, 8'h00); // power down all off
		@(posedge i_clk_sys);
		i_ce <= 1'b0;
		i_lwk_host.wr(6'h00, 8'h0e);
		@(posedge i_clk_sys);
		i_ce <= 1'b1;
		rc(6'h00, 8'h0f); // frozen write not taken
		i_lwk_host.wr(6'h06, 8'h00);
		@(posedge i_clk_sys);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		rc(6'h06, 8'h96); // second reset restores first byte
		rc(6'h00, 8'h0e); // second reset restores enables
	endtask : t_power
	task automatic t_recv;
		@(posedge i_clk_sys);
		fe.carrier <= 1'b1;
		i_lwk_host.wr(6'h01, 8'h27);
		hit(2'b01);
		chk({7'h0, recv}, 8'h00); // one hit not enough
		hit(2'b01);
		chk({6'h0, wake, recv}, 8'h03); // second hit wakes
		i_lwk_host.cmd(6'h00);
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk({7'h0, recv}, 8'h00); // clear wake listens
		i_lwk_host.wr(6'h01, 8'h21);
		hit(2'b10);
		chk({7'h0, recv}, 8'h01); // frequency alone wakes
		i_lwk_host.cmd(6'h00);
		fe.carrier <= 1'b0;
	endtask : t_recv
	// one second interval with no carrier gives a 1280 cycle pulse
	task automatic t_awu;
		int w;
		i_lwk_host.wr(6'h08, 8'h01);
		w = 0;
		while (wake !== 1'b1 && w < 3 * SEC) begin
			@(posedge i_clk_sys);
			#1;
			w++;
		end
		chk({7'h0, wake}, 8'h01); // interval elapses
		w = 0;
		while (wake === 1'b1) begin
			@(posedge i_clk_sys);
			#1;
			w++;
		end
		chk(w[10:3], 8'ha0); // pulse width 1280
		chk({5'h0, w[2:0]}, 8'h00); // pulse width 1280
	endtask : t_awu
	task automatic close_out;
		if (errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////////////
	// watchdog well above the longest run
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		t_defaults();
		t_write();
		t_status();
		t_recv();
		t_power();
		t_awu();
		close_out();
	end
endmodule : lwk_regbank_test
